// ---- ioc_pkg.sv ----
// Shared constants and mode types for the I/O cell register block
package ioc_pkg;

	// Input path mode selection
	typedef enum logic [1:0] {
		IOC_IN_BYPASS = 2'h0,
		IOC_IN_SDR    = 2'h1,
		IOC_IN_DDR    = 2'h2
	} ioc_in_mode_type;

	// Input delay selection
	typedef enum logic [1:0] {
		IOC_DLY_NONE    = 2'h0,
		IOC_DLY_FIXED   = 2'h1,
		IOC_DLY_DYNAMIC = 2'h2
	} ioc_dly_mode_type;

	// Output path mode selection
	typedef enum logic {
		IOC_OUT_SDR = 1'h0,
		IOC_OUT_DDR = 1'h1
	} ioc_out_mode_type;

	// Delay line geometry and fixed delay tap
	localparam int unsigned IOC_DLY_SEL_W     = 5;
	localparam int unsigned IOC_DLY_TAPS      = 32;
	localparam logic [4:0]  IOC_FIXED_DLY_TAP = 5'h04;

	// Values taken by the cell registers after reset or local set/reset
	localparam logic IOC_INIT_DATA = 1'h0;
	localparam logic IOC_INIT_OE   = 1'h0;

	// Capture stream buffer
	localparam int unsigned IOC_FIFO_DEPTH = 16;
	localparam int unsigned IOC_FIFO_WIDTH = 2;

	// Clock figures: 40 MHz system clock
	localparam int unsigned IOC_CLK_PERIOD_NS = 25;

endpackage : ioc_pkg

// ---- ioc_fifo.sv ----
// Synchronous valid/ready FIFO built from flip-flops
`timescale 1ns/1ps
`default_nettype none

module ioc_fifo #(
	parameter int unsigned WIDTH = ioc_pkg::IOC_FIFO_WIDTH,
	parameter int unsigned DEPTH = ioc_pkg::IOC_FIFO_DEPTH
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             flush_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	import ioc_pkg::*;

	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	wire  logic       full;
	wire  logic       empty;
	wire  logic       push;
	wire  logic       pop;

	// Extra pointer bit tells full from empty when the indices meet
	assign empty       = (wr_q == rd_q);
	assign full        = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign push        = in_valid_i && !full;
	assign pop         = out_ready_i && !empty;
	assign out_data_o  = mem_q[rd_q[AW-1:0]];

	// Storage words are written only on an accepted push
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data_i;
		end
	end

	// Pointers; flush empties the buffer without touching storage
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
		end else if (flush_i) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_q + (AW+1)'(push);
			rd_q <= rd_q + (AW+1)'(pop);
		end
	end

endmodule // ioc_fifo

`default_nettype wire

// ---- ioc_cell.sv ----
// I/O cell with input, output and tri-state register groups
//
// Operation
// - Cell holds separate input, output and output-enable register groups.
// - Bypass mode passes pad input straight to core, also as a clock.
// - A fixed input delay may be placed ahead of the capture registers.
// - Bottom-side cells add a dynamic delay chosen by a five-bit select.
// - Single-rate mode captures pad input in one register on the clock edge.
// - Dual-edge mode captures on rising and falling edges, two parallel streams.
// - First capture output gives the rising-edge sample in dual-edge mode.
// - Second capture output gives the single-rate or the falling-edge sample.
// - Tri-state group registers core output enable and drives pad enable.
// - One system clock runs input, output and tri-state groups.
// - Local set/reset forces the input, output and tri-state registers to their initial values.
`timescale 1ns/1ps
`default_nettype none

module ioc_cell #(
	parameter bit          BOTTOM_SIDE = 1'b1,
	parameter int unsigned DLY_TAPS    = ioc_pkg::IOC_DLY_TAPS,
	parameter int unsigned FIFO_DEPTH  = ioc_pkg::IOC_FIFO_DEPTH
) (
	input  wire logic                                clk_i,
	input  wire logic                                rst_i,
	input  wire logic                                lsr_i,
	input  wire logic                                ce_i,
	input  wire logic                                pad_in_i,
	input  wire ioc_pkg::ioc_in_mode_type            in_mode_i,
	input  wire ioc_pkg::ioc_dly_mode_type           dly_mode_i,
	input  wire logic [ioc_pkg::IOC_DLY_SEL_W-1:0]   dynamic_delay_select_i,
	input  wire ioc_pkg::ioc_out_mode_type           out_mode_i,
	input  wire logic                                core_out_first_word_i,
	input  wire logic                                core_out_second_word_i,
	input  wire logic                                core_output_enable_in_i,
	output logic                                     input_bypass_data_o,
	output logic                                     input_bypass_clock_o,
	output logic                                     rise_capture_out_o,
	output logic                                     fall_or_single_capture_out_o,
	output logic                                     cap_valid_o,
	input  wire logic                                cap_ready_i,
	output logic [ioc_pkg::IOC_FIFO_WIDTH-1:0]       cap_word_o,
	output logic                                     cap_fill_ready_o,
	output logic                                     cap_overflow_o,
	output logic                                     pad_out_o,
	output logic                                     pad_output_enable_out_o
);
	import ioc_pkg::*;

	localparam int unsigned TW = $clog2(DLY_TAPS);

	// Pick the delay tap; decoded once and shared by both edge streams
	function automatic logic [TW-1:0] tap_sel(
		input ioc_dly_mode_type      mode,
		input logic [IOC_DLY_SEL_W-1:0] sel
	);
		logic [TW-1:0] t;
		t = '0;
		if (mode == IOC_DLY_FIXED) begin
			t = TW'(IOC_FIXED_DLY_TAP);
		end else if (mode == IOC_DLY_DYNAMIC && BOTTOM_SIDE) begin
			t = TW'(sel);
		end
		return t;
	endfunction

	// Pad synchronisers, one per clock edge
	logic       pos_s1_q;
	logic       pos_s2_q;
	logic       neg_s1_q;
	logic       neg_s2_q;

	// Delay lines on the synchronised pad samples
	logic [DLY_TAPS-1:0] pos_line_q;
	logic [DLY_TAPS-1:0] pos_line_d;
	logic [DLY_TAPS-1:0] neg_line_q;
	logic [DLY_TAPS-1:0] neg_line_d;

	// Input register group
	logic       rise_q;
	logic       rise_d;
	logic       fall_raw_q;
	logic       fall_raw_d;
	logic       fall_single_q;
	logic       fall_single_d;
	logic       cap_push_q;
	logic       cap_push_d;
	logic       overflow_q;
	logic       overflow_d;

	// Output and tri-state register groups
	logic       out_first_q;
	logic       out_first_d;
	logic       out_second_q;
	logic       out_second_d;
	logic       oe_q;
	logic       oe_d;

	wire  logic [TW-1:0] tap;
	wire  logic          pos_tap;
	wire  logic          neg_tap;
	wire  logic          is_ddr_in;
	wire  logic          is_sdr_in;
	wire  logic          is_bypass;
	wire  logic          fifo_in_ready;

	// Mode decode
	assign is_bypass = (in_mode_i == IOC_IN_BYPASS);
	assign is_sdr_in = (in_mode_i == IOC_IN_SDR);
	assign is_ddr_in = (in_mode_i == IOC_IN_DDR);

	// Bypass path never sees a register or delay element
	assign input_bypass_data_o  = is_bypass ? pad_in_i : 1'b0;
	assign input_bypass_clock_o = is_bypass ? pad_in_i : 1'b0;

	// Rising-edge synchroniser; the first stage feeds only the second
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pos_s1_q <= IOC_INIT_DATA;
			pos_s2_q <= IOC_INIT_DATA;
		end else begin
			pos_s1_q <= pad_in_i;
			pos_s2_q <= pos_s1_q;
		end
	end

	// Falling-edge synchroniser keeps the low-phase sample stream apart
	always_ff @(negedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			neg_s1_q <= IOC_INIT_DATA;
			neg_s2_q <= IOC_INIT_DATA;
		end else begin
			neg_s1_q <= pad_in_i;
			neg_s2_q <= neg_s1_q;
		end
	end

	// Delay line shifting: tap 0 is the undelayed sample
	assign pos_line_d[0] = pos_s2_q;
	assign neg_line_d[0] = neg_s2_q;
	for (genvar i = 1; i < DLY_TAPS; i++) begin : g_dly
		assign pos_line_d[i] = pos_line_q[i-1];
		assign neg_line_d[i] = neg_line_q[i-1];
	end

	// The lines run freely so a tap change sees settled history at once
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pos_line_q <= '0;
		end else begin
			pos_line_q <= pos_line_d;
		end
	end

	always_ff @(negedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			neg_line_q <= '0;
		end else begin
			neg_line_q <= neg_line_d;
		end
	end

	// Same tap on both edges keeps the two streams aligned
	assign tap     = tap_sel(dly_mode_i, dynamic_delay_select_i);
	assign pos_tap = pos_line_q[tap];
	assign neg_tap = neg_line_q[tap];

	// Next values of the input group; ce low holds, lsr wins over ce
	always_comb begin
		rise_d        = rise_q;
		fall_raw_d    = fall_raw_q;
		fall_single_d = fall_single_q;
		if (lsr_i) begin
			rise_d        = IOC_INIT_DATA;
			fall_raw_d    = IOC_INIT_DATA;
			fall_single_d = IOC_INIT_DATA;
		end else if (ce_i) begin
			if (is_sdr_in) begin
				fall_single_d = pos_tap;
			end else if (is_ddr_in) begin
				rise_d        = pos_tap;
				fall_raw_d    = neg_tap;
				fall_single_d = fall_raw_q;
			end
		end
	end

	// Rising-edge input registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rise_q        <= IOC_INIT_DATA;
			fall_single_q <= IOC_INIT_DATA;
		end else begin
			rise_q        <= rise_d;
			fall_single_q <= fall_single_d;
		end
	end

	// Falling-edge sample, retimed to the rising edge through fall_single_q
	always_ff @(negedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fall_raw_q <= IOC_INIT_DATA;
		end else begin
			fall_raw_q <= fall_raw_d;
		end
	end

	// Capture outputs: rise stream on the first, single or fall on the second
	assign rise_capture_out_o           = rise_q;
	assign fall_or_single_capture_out_o = fall_single_q;

	// One word is pushed for every enabled rising clock edge outside bypass
	assign cap_push_d = !lsr_i && ce_i && !is_bypass;

	// A full buffer drops the word and latches an overflow flag until lsr
	assign overflow_d = lsr_i ? 1'b0 : (overflow_q || (cap_push_q && !fifo_in_ready));

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cap_push_q <= 1'b0;
			overflow_q <= 1'b0;
		end else begin
			cap_push_q <= cap_push_d;
			overflow_q <= overflow_d;
		end
	end

	assign cap_overflow_o   = overflow_q;
	assign cap_fill_ready_o = fifo_in_ready;

	// Capture stream buffer toward core logic that may stall
	ioc_fifo #(
		.WIDTH (IOC_FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_cap_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.flush_i     (lsr_i),
		.in_valid_i  (cap_push_q),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   ({rise_q, fall_single_q}),
		.out_valid_o (cap_valid_o),
		.out_ready_i (cap_ready_i),
		.out_data_o  (cap_word_o)
	);

	// Output and tri-state next values; second word only matters in DDR
	always_comb begin
		out_first_d  = out_first_q;
		out_second_d = out_second_q;
		oe_d         = oe_q;
		if (lsr_i) begin
			out_first_d  = IOC_INIT_DATA;
			out_second_d = IOC_INIT_DATA;
			oe_d         = IOC_INIT_OE;
		end else if (ce_i) begin
			out_first_d = core_out_first_word_i;
			if (out_mode_i == IOC_OUT_DDR) begin
				out_second_d = core_out_second_word_i;
			end
			oe_d = core_output_enable_in_i;
		end
	end

	// Output register group and tri-state register group
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			out_first_q  <= IOC_INIT_DATA;
			out_second_q <= IOC_INIT_DATA;
			oe_q         <= IOC_INIT_OE;
		end else begin
			out_first_q  <= out_first_d;
			out_second_q <= out_second_d;
			oe_q         <= oe_d;
		end
	end

	// Clock-phase mux: simplest DDR serialiser, but glitches if the clock
	// edge and a register update race, so keep this path short in layout
	assign pad_out_o = (out_mode_i == IOC_OUT_DDR) ?
		(clk_i ? out_first_q : out_second_q) : out_first_q;

	assign pad_output_enable_out_o = oe_q;

endmodule // ioc_cell

`default_nettype wire

// ---- ioc_cell_asserts.sv ----
// Concurrent checks on the I/O cell ports
`timescale 1ns/1ps
`default_nettype none
module ioc_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic lsr_i,
	input wire logic ce_i,
	input wire logic pad_in_i,
	input wire ioc_pkg::ioc_in_mode_type in_mode_i,
	input wire ioc_pkg::ioc_dly_mode_type dly_mode_i,
	input wire ioc_pkg::ioc_out_mode_type out_mode_i,
	input wire logic core_out_first_word_i,
	input wire logic core_out_second_word_i,
	input wire logic core_output_enable_in_i,
	input wire logic input_bypass_data_o,
	input wire logic input_bypass_clock_o,
	input wire logic rise_capture_out_o,
	input wire logic fall_or_single_capture_out_o,
	input wire logic cap_overflow_o,
	input wire logic pad_out_o,
	input wire logic pad_output_enable_out_o
);
	import ioc_pkg::*;
	logic [5:0] run_q;
	logic run_ok;
	// Run length of enabled single-rate cycles; a delay change restarts it
	assign run_ok = in_mode_i == IOC_IN_SDR && ce_i && !lsr_i;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			run_q <= 6'h00;
		end else if (!run_ok || !$stable(dly_mode_i)) begin
			run_q <= 6'h00;
		end else if (run_q != 6'h3F) begin
			run_q <= run_q + 6'h01;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_bypass_data: assert property (in_mode_i == IOC_IN_BYPASS |-> input_bypass_data_o == pad_in_i)
		else $error("bypass data differs from pad");
	a_bypass_clock: assert property (in_mode_i == IOC_IN_BYPASS |-> input_bypass_clock_o == pad_in_i)
		else $error("bypass clock differs from pad");
	a_sdr_latency: assert property (run_q > 6'h04 && dly_mode_i == IOC_DLY_NONE && $stable(dly_mode_i) |-> fall_or_single_capture_out_o == $past(pad_in_i, 4))
		else $error("single-rate capture latency wrong");
	a_fixed_delay: assert property (run_q > 6'h08 && dly_mode_i == IOC_DLY_FIXED && $stable(dly_mode_i) |-> fall_or_single_capture_out_o == $past(pad_in_i, 8))
		else $error("fixed delay latency wrong");
	a_ce_hold: assert property (!ce_i && !lsr_i |=> $stable(fall_or_single_capture_out_o) && $stable(rise_capture_out_o) && $stable(pad_output_enable_out_o))
		else $error("register moved with enable low");
	a_lsr_clear: assert property (lsr_i |=> !rise_capture_out_o && !fall_or_single_capture_out_o && !pad_output_enable_out_o && !cap_overflow_o)
		else $error("local reset did not clear");
	a_oe_follow: assert property (ce_i && !lsr_i |=> pad_output_enable_out_o == $past(core_output_enable_in_i))
		else $error("pad enable not loaded");
	a_sdr_word: assert property (ce_i && !lsr_i && out_mode_i == IOC_OUT_SDR |=> out_mode_i != IOC_OUT_SDR || pad_out_o == $past(core_out_first_word_i))
		else $error("single-rate pad word wrong");
	a_ddr_low: assert property (ce_i && !lsr_i && out_mode_i == IOC_OUT_DDR |=> out_mode_i != IOC_OUT_DDR || pad_out_o == $past(core_out_second_word_i))
		else $error("low phase word wrong");
	c_ddr_in: cover property (in_mode_i == IOC_IN_DDR && rise_capture_out_o != fall_or_single_capture_out_o);
	c_overflow: cover property ($rose(cap_overflow_o));
	c_ddr_out: cover property (out_mode_i == IOC_OUT_DDR && pad_out_o);
endmodule // ioc_chk
bind ioc_cell ioc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .lsr_i(lsr_i), .ce_i(ce_i),
	.pad_in_i(pad_in_i), .in_mode_i(in_mode_i), .dly_mode_i(dly_mode_i), .out_mode_i(out_mode_i),
	.core_out_first_word_i(core_out_first_word_i), .core_out_second_word_i(core_out_second_word_i),
	.core_output_enable_in_i(core_output_enable_in_i), .input_bypass_data_o(input_bypass_data_o),
	.input_bypass_clock_o(input_bypass_clock_o), .rise_capture_out_o(rise_capture_out_o),
	.fall_or_single_capture_out_o(fall_or_single_capture_out_o), .cap_overflow_o(cap_overflow_o),
	.pad_out_o(pad_out_o), .pad_output_enable_out_o(pad_output_enable_out_o));
`default_nettype wire

// ---- ioc_pad_model.sv ----
// Pad-side source that moves the pad between clock edges
`timescale 1ns/1ps
`default_nettype none
module ioc_pad_model (
	input  wire logic clk_i,
	input  wire logic high_first_i,
	output logic      pad_o
);
	// Quarter-period lag so neither capture edge races a pad change
	initial pad_o = 1'b0;
	always @(clk_i) begin
		pad_o <= #6 (clk_i == high_first_i);
	end
endmodule // ioc_pad_model
`default_nettype wire

// ---- ioc_cell_bench.sv ----
// Self-checking bench for the I/O cell register block
`timescale 1ns/1ps
`default_nettype none
module ioc_cell_bench;
	import ioc_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, lsr_i = 1'b0, ce_i = 1'b1, pad_q = 1'b0, mdl_en = 1'b0;
	logic hi_first = 1'b1, rdy = 1'b0, d0 = 1'b0, d1 = 1'b0, oe = 1'b0, mdl_pad, pad_in;
	logic [4:0] sel = 5'h00;
	ioc_in_mode_type in_mode = IOC_IN_SDR;
	ioc_dly_mode_type dly = IOC_DLY_NONE;
	ioc_out_mode_type om = IOC_OUT_SDR;
	logic byp_d, byp_c, rise, fall, cval, cfr, covf, pout, poe;
	logic [1:0] cword;
	int bad_count = 0, samples_checked = 0;
	// 40 MHz clock; pad comes from the bench or the phase-shifted model
	always #12.5 clk_i = ~clk_i;
	assign pad_in = mdl_en ? mdl_pad : pad_q;
	ioc_cell uut (.clk_i(clk_i), .rst_i(rst_i), .lsr_i(lsr_i), .ce_i(ce_i), .pad_in_i(pad_in),
		.in_mode_i(in_mode), .dly_mode_i(dly), .dynamic_delay_select_i(sel), .out_mode_i(om),
		.core_out_first_word_i(d0), .core_out_second_word_i(d1), .core_output_enable_in_i(oe),
		.input_bypass_data_o(byp_d), .input_bypass_clock_o(byp_c), .rise_capture_out_o(rise),
		.fall_or_single_capture_out_o(fall), .cap_valid_o(cval), .cap_ready_i(rdy),
		.cap_word_o(cword), .cap_fill_ready_o(cfr), .cap_overflow_o(covf), .pad_out_o(pout),
		.pad_output_enable_out_o(poe));
	ioc_pad_model u_pad (.clk_i(clk_i), .high_first_i(hi_first), .pad_o(mdl_pad));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic t_bypass();
		@(posedge clk_i);
		in_mode <= IOC_IN_BYPASS;
		pad_q <= 1'b1;
		cyc(1);
		chk(8'({byp_d, byp_c}), 8'h03);
		@(posedge clk_i);
		pad_q <= 1'b0;
		#1;
		chk(8'({byp_d, byp_c}), 8'h00);
	endtask
	// Edges from a pad rise to the single-rate output; the loop bound also catches a hang
	task automatic t_sdr(input ioc_dly_mode_type m, input logic [4:0] s, input int lat);
		int n;
		@(posedge clk_i);
		in_mode <= IOC_IN_SDR;
		dly <= m;
		sel <= s;
		pad_q <= 1'b0;
		cyc(40);
		@(posedge clk_i);
		pad_q <= 1'b1;
		for (n = 0; n < 60 && fall !== 1'b1; n++) begin
			cyc(1);
		end
		chk(8'(n), 8'(lat));
		chk(8'({byp_d, byp_c}), 8'h00);
	endtask
	task automatic t_ddr(input logic hf, input logic [7:0] exp);
		@(posedge clk_i);
		in_mode <= IOC_IN_DDR;
		hi_first <= hf;
		mdl_en <= 1'b1;
		cyc(50);
		chk(8'({rise, fall}), exp);
	endtask
	task automatic t_ce();
		@(posedge clk_i);
		{mdl_en, pad_q, oe, d0} <= 4'h0;
		in_mode <= IOC_IN_SDR;
		dly <= IOC_DLY_NONE;
		om <= IOC_OUT_SDR;
		cyc(10);
		@(posedge clk_i);
		{ce_i, pad_q, oe, d0} <= 4'h7;
		cyc(10);
		chk(8'({rise, fall, poe, pout}), 8'h08);
		@(posedge clk_i);
		ce_i <= 1'b1;
		cyc(6);
		chk(8'({rise, fall, poe, pout}), 8'h0F);
	endtask
	task automatic t_lsr();
		@(posedge clk_i);
		lsr_i <= 1'b1;
		cyc(2);
		chk(8'({rise, fall, poe, pout, covf, cval}), 8'h00);
		@(posedge clk_i);
		lsr_i <= 1'b0;
	endtask
	// Fill until refused, then drain with the reader stalling every other cycle
	task automatic t_fifo();
		int n;
		logic [1:0] w;
		for (n = 0; n < 40 && cfr === 1'b1; n++) begin
			cyc(1);
		end
		cyc(3);
		chk(8'({cfr, covf, cval}), 8'h03);
		@(posedge clk_i);
		in_mode <= IOC_IN_BYPASS;
		cyc(3);
		n = 0;
		w = 2'h0;
		for (int i = 0; i < 80; i++) begin
			@(posedge clk_i);
			if (rdy && cval) begin
				n++;
				w = cword;
			end
			rdy <= ~rdy;
		end
		chk(8'(n), 8'(IOC_FIFO_DEPTH));
		chk(8'({w, covf, cval}), 8'h06);
	endtask
	task automatic t_out(input ioc_out_mode_type m, input logic a, input logic b, input logic [7:0] exp);
		logic h;
		@(posedge clk_i);
		om <= m;
		{d0, d1} <= {a, b};
		cyc(2);
		#5;
		h = pout;
		@(negedge clk_i);
		#5;
		chk(8'({h, pout}), exp);
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		#1;
		chk(8'({rise, fall, pout, poe, cval, cfr}), 8'h01);
		@(posedge clk_i);
		rst_i <= 1'b0;
		t_bypass();
		t_sdr(IOC_DLY_NONE, 5'h1F, 4);
		t_sdr(IOC_DLY_FIXED, 5'h00, 4 + int'(IOC_FIXED_DLY_TAP));
		t_sdr(IOC_DLY_DYNAMIC, 5'h1F, 35);
		t_sdr(IOC_DLY_DYNAMIC, 5'h09, 13);
		t_ddr(1'b1, 8'h01);
		t_ddr(1'b0, 8'h02);
		t_ce();
		t_lsr();
		t_fifo();
		t_out(IOC_OUT_DDR, 1'b1, 1'b0, 8'h02);
		t_out(IOC_OUT_DDR, 1'b0, 1'b1, 8'h01);
		t_out(IOC_OUT_SDR, 1'b1, 1'b0, 8'h03);
		t_out(IOC_OUT_SDR, 1'b0, 1'b1, 8'h00);
		summarize();
	end
endmodule // ioc_cell_bench
`default_nettype wire
